//--- logic/rlcs_map.svh
// Functional notes
// [R1] remote lines except alive and ready are active low: low means true, high means false
// [R2] lines are only pulled low or released; wired-OR of all units
// [R3] fault asserts safety halt; halt input stops our hazardous actions
// [R4] all-alive line high only while every module is on; monitored
// [R5] ready line is active high; system ready for next analysis
// [R6] pre-run setup request low asks modules for pre-analysis work
// [R7] start low requests run or timetable start
// [R8] stop low requests return to ready state quickly
// [R9] injection request low asks autosampler to start injection cycle
// [R10] switches 1-2 select set: 00 bus addr, 01 serial, 10 rsvd, 11 boot
// [R11] switch down reads 0, up reads 1
// [R12] bus address set takes switches 3-8 as binary address
// [R13] changed setting committed to storage only at next power-up
// [R14] each parameter set stored separately; only selected set overwritten
// [R15] default bus address is decimal 24, pattern 00011000
// [R16] serial port is DCE: drives TXD, DTR, RTS; samples the rest
// [R17] switches 3-5 select the baud rate per table
// [R18] one start, one stop bit; switch 6 data bits; 7-8 parity
// [R19] flow control only by CTS/RTS hardware handshake
// [R20] boot pattern with cold start flag erases methods, keeps logs
// [R21] every remote input passes a two-stage synchronizer
// [R22] switch bank sampled once at power-up; later changes ignored
`ifndef RLCS_MAP_SVH
`define RLCS_MAP_SVH
`define RLCS_SEL_BUS        2'h0
`define RLCS_SEL_SERIAL     2'h1
`define RLCS_SEL_RSVD       2'h2
`define RLCS_SEL_BOOT       2'h3
`define RLCS_DEF_ADDR       6'h18
`define RLCS_DEF_BAUD       3'h6
`define RLCS_DEF_DATA8      1'h1
`define RLCS_DEF_PARITY     2'h0
`define RLCS_BOOT_COLD      6'h01
`define RLCS_BOOT_RESIDENT  6'h08
`define RLCS_SETTLE_NS      1000
`define RLCS_CLK_NS         10
`define RLCS_SETTLE_CYC     ((`RLCS_SETTLE_NS + `RLCS_CLK_NS - 1) / `RLCS_CLK_NS)
`endif

//--- logic/rlcs_pkg.sv
`default_nettype none
package rlcs_pkg;
  typedef struct packed {
    logic [5:0] addr;
  } rlcs_bus_set_s;
  typedef struct packed {
    logic [2:0] baud;
    logic       data8;
    logic [1:0] parity;
  } rlcs_ser_set_s;
  // true-level view of the remote lines (1 = condition true)
  typedef struct packed {
    logic halt;
    logic alive;
    logic ready;
    logic prep;
    logic start;
    logic stop;
    logic inject;
  } rlcs_remote_s;
  typedef enum logic [1:0] {
    RLCS_BOOT_IDLE  = 2'b00,
    RLCS_BOOT_WAIT  = 2'b01,
    RLCS_BOOT_WRITE = 2'b10,
    RLCS_BOOT_DONE  = 2'b11
  } rlcs_boot_e;
endpackage
`default_nettype wire

//--- logic/rlcs_sync.sv
`timescale 1ns/1ns
`default_nettype none
module rlcs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb
  begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  // two flops; first read only by second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= '1;
      q      <= '1;
    end
    else
    begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule
`default_nettype wire

//--- logic/rlcs_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "rlcs_map.svh"
module rlcs_top (
  // clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RST,
  // remote line inputs (pin level, active low except alive/ready)
  input  wire logic                   HALT_N_I,
  input  wire logic                   ALIVE_I,
  input  wire logic                   READY_I,
  input  wire logic                   PREP_N_I,
  input  wire logic                   START_N_I,
  input  wire logic                   STOP_N_I,
  input  wire logic                   INJECT_N_I,
  // remote line open-drain drive enables (high = pull low)
  output var  logic                   HALT_OE,
  output var  logic                   ALIVE_OE,
  output var  logic                   READY_OE,
  output var  logic                   PREP_OE,
  output var  logic                   START_OE,
  output var  logic                   STOP_OE,
  output var  logic                   INJECT_OE,
  // remote line output levels (always low when enabled)
  output var  logic                   REMOTE_O,
  // local requests from module logic
  input  wire logic                   FAULT,
  input  wire logic                   UNIT_ON,
  input  wire logic                   UNIT_READY,
  input  wire logic                   REQ_PREP,
  input  wire logic                   REQ_START,
  input  wire logic                   REQ_STOP,
  input  wire logic                   REQ_INJECT,
  // synchronized remote status, true-level
  output var  rlcs_pkg::rlcs_remote_s REMOTE_STATE,
  output var  logic                   SAFE_STOP,
  output var  logic                   PEERS_OFF,
  output var  logic                   DO_PREP,
  output var  logic                   DO_START,
  output var  logic                   DO_STOP,
  // configuration switch bank, bit 0 = switch 1, up = 1
  input  wire logic [7:0]             CFG_SW,
  // non-volatile store write port
  output var  logic                   NV_WR_BUS,
  output var  logic                   NV_WR_SER,
  output var  logic                   NV_ERASE,
  output var  rlcs_pkg::rlcs_bus_set_s NV_BUS_D,
  output var  rlcs_pkg::rlcs_ser_set_s NV_SER_D,
  input  wire rlcs_pkg::rlcs_bus_set_s NV_BUS_Q,
  input  wire rlcs_pkg::rlcs_ser_set_s NV_SER_Q,
  input  wire logic                   NV_VALID,
  // decoded configuration
  output var  logic [1:0]             CFG_SEL,
  output var  rlcs_pkg::rlcs_bus_set_s BUS_SET,
  output var  rlcs_pkg::rlcs_ser_set_s SER_SET,
  output var  logic                   STAY_RESIDENT,
  output var  logic                   CFG_DONE,
  // serial port, DCE side
  input  wire logic                   RXD_I,
  input  wire logic                   DCD_I,
  input  wire logic                   DSR_I,
  input  wire logic                   CTS_I,
  input  wire logic                   RI_I,
  input  wire logic                   TXD_IN,
  input  wire logic                   DTR_IN,
  input  wire logic                   RTS_IN,
  input  wire logic                   TX_WANT,
  output var  logic                   TXD_O,
  output var  logic                   DTR_O,
  output var  logic                   RTS_O,
  output var  logic                   TX_ALLOW,
  output var  logic [4:0]             SER_IN
);
  import rlcs_pkg::*;

  localparam int SETTLE_CYC = `RLCS_SETTLE_CYC;

  // ----------------------------------------------------------------
  // remote input synchronizers
  // ----------------------------------------------------------------
  logic [6:0] rem_pin;
  logic [6:0] rem_sync;
  logic [4:0] ser_sync;
  logic [7:0] sw_sync;

  assign rem_pin = {HALT_N_I, ALIVE_I, READY_I, PREP_N_I,
                    START_N_I, STOP_N_I, INJECT_N_I};

  // [R21] two-stage sync
  rlcs_sync #(.W(7)) u_rem_sync (
    .clk (CLK),
    .rst (RST),
    .d   (rem_pin),
    .q   (rem_sync)
  );

  rlcs_sync #(.W(5)) u_ser_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({RXD_I, DCD_I, DSR_I, CTS_I, RI_I}),
    .q   (ser_sync)
  );

  rlcs_sync #(.W(8)) u_sw_sync (
    .clk (CLK),
    .rst (RST),
    .d   (CFG_SW),
    .q   (sw_sync)
  );

  // ----------------------------------------------------------------
  // remote line drive and status
  // ----------------------------------------------------------------
  rlcs_remote_s st_nxt;
  logic [6:0]   oe_nxt;
  logic         safe_nxt;
  logic         peers_off_nxt;
  logic         do_prep_nxt;
  logic         do_start_nxt;
  logic         do_stop_nxt;

  always_comb
  begin
    // [R1] invert active-low lines to true-level
    st_nxt.halt   = ~rem_sync[6];
    st_nxt.alive  = rem_sync[5];
    // [R5] ready is active high
    st_nxt.ready  = rem_sync[4];
    st_nxt.prep   = ~rem_sync[3];
    st_nxt.start  = ~rem_sync[2];
    st_nxt.stop   = ~rem_sync[1];
    st_nxt.inject = ~rem_sync[0];
    // [R2] pull low or release only
    // [R3] fault drives safety halt
    oe_nxt[6] = FAULT;
    // [R4] pull alive low while this unit is off
    oe_nxt[5] = ~UNIT_ON;
    // [R5] hold ready low while not ready
    oe_nxt[4] = ~UNIT_READY;
    // [R6] prep request
    oe_nxt[3] = REQ_PREP;
    // [R7] start request
    oe_nxt[2] = REQ_START;
    // [R8] stop request
    oe_nxt[1] = REQ_STOP;
    // [R9] injection request, autosampler acts
    oe_nxt[0] = REQ_INJECT;
    // [R3] react to halt
    safe_nxt      = st_nxt.halt;
    // [R4] monitor alive line
    peers_off_nxt = ~st_nxt.alive;
    // [R6] respond to prep unless halted
    do_prep_nxt   = st_nxt.prep & ~st_nxt.halt;
    // [R7] run-time activities start
    do_start_nxt  = st_nxt.start & ~st_nxt.halt & ~st_nxt.stop;
    // [R8] stop wins over start
    do_stop_nxt   = st_nxt.stop | st_nxt.halt;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      REMOTE_STATE <= '0;
      {HALT_OE, ALIVE_OE, READY_OE, PREP_OE,
       START_OE, STOP_OE, INJECT_OE} <= 7'h30;
      REMOTE_O  <= 1'b0;
      SAFE_STOP <= 1'b0;
      PEERS_OFF <= 1'b1;
      DO_PREP   <= 1'b0;
      DO_START  <= 1'b0;
      DO_STOP   <= 1'b0;
    end
    else
    begin
      REMOTE_STATE <= st_nxt;
      {HALT_OE, ALIVE_OE, READY_OE, PREP_OE,
       START_OE, STOP_OE, INJECT_OE} <= oe_nxt;
      REMOTE_O  <= 1'b0;
      SAFE_STOP <= safe_nxt;
      PEERS_OFF <= peers_off_nxt;
      DO_PREP   <= do_prep_nxt;
      DO_START  <= do_start_nxt;
      DO_STOP   <= do_stop_nxt;
    end
  end

  // ----------------------------------------------------------------
  // power-up switch capture and store
  // ----------------------------------------------------------------
  rlcs_boot_e    boot_r;
  rlcs_boot_e    boot_nxt;
  logic [7:0]    sw_r;
  logic [7:0]    sw_nxt;
  logic [15:0]   cnt_r;
  logic [15:0]   cnt_nxt;
  rlcs_bus_set_s bus_nxt;
  rlcs_ser_set_s ser_nxt;
  logic          wr_bus_nxt;
  logic          wr_ser_nxt;
  logic          erase_nxt;
  logic          res_nxt;
  logic [1:0]    sel;
  logic [5:0]    sw_field;

  // [R11] switch bit is 1 when up
  // [R10] switches 1-2 select the set
  assign sel = {sw_r[0], sw_r[1]};
  assign sw_field = {sw_r[2], sw_r[3], sw_r[4], sw_r[5], sw_r[6], sw_r[7]};

  always_comb
  begin
    boot_nxt   = boot_r;
    sw_nxt     = sw_r;
    cnt_nxt    = cnt_r;
    bus_nxt    = BUS_SET;
    ser_nxt    = SER_SET;
    wr_bus_nxt = 1'b0;
    wr_ser_nxt = 1'b0;
    erase_nxt  = 1'b0;
    res_nxt    = STAY_RESIDENT;
    unique case (boot_r)
      RLCS_BOOT_IDLE:
      begin
        cnt_nxt  = '0;
        boot_nxt = RLCS_BOOT_WAIT;
      end
      RLCS_BOOT_WAIT:
      begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r >= 16'(SETTLE_CYC))
        begin
          // [R22] single sample at power-up
          sw_nxt   = sw_sync;
          boot_nxt = RLCS_BOOT_WRITE;
          // [R14] load previously stored sets
          if (NV_VALID)
          begin
            bus_nxt = NV_BUS_Q;
            ser_nxt = NV_SER_Q;
          end
        end
      end
      RLCS_BOOT_WRITE:
      begin
        boot_nxt = RLCS_BOOT_DONE;
        // [R13] commit only during power-up
        // [R14] only the selected set is written
        unique case (sel)
          `RLCS_SEL_BUS:
          begin
            // [R12] switches 3-8 bus address
            bus_nxt.addr = sw_field;
            wr_bus_nxt   = 1'b1;
          end
          `RLCS_SEL_SERIAL:
          begin
            // [R17] baud code from switches 3-5
            ser_nxt.baud   = sw_field[5:3];
            // [R18] data bits and parity
            ser_nxt.data8  = sw_field[2];
            ser_nxt.parity = sw_field[1:0];
            wr_ser_nxt     = 1'b1;
          end
          `RLCS_SEL_RSVD:
          begin
            wr_bus_nxt = 1'b0;
          end
          `RLCS_SEL_BOOT:
          begin
            // [R20] cold start flag erases methods
            erase_nxt = (sw_field == `RLCS_BOOT_COLD);
            res_nxt   = (sw_field == `RLCS_BOOT_RESIDENT);
          end
        endcase
      end
      RLCS_BOOT_DONE:
      begin
        boot_nxt = RLCS_BOOT_DONE;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      boot_r        <= RLCS_BOOT_IDLE;
      sw_r          <= 8'h00;
      cnt_r         <= 16'h0000;
      // [R15] default address 24
      BUS_SET       <= '{addr: `RLCS_DEF_ADDR};
      SER_SET       <= '{baud: `RLCS_DEF_BAUD, data8: `RLCS_DEF_DATA8,
                         parity: `RLCS_DEF_PARITY};
      NV_WR_BUS     <= 1'b0;
      NV_WR_SER     <= 1'b0;
      NV_ERASE      <= 1'b0;
      NV_BUS_D      <= '0;
      NV_SER_D      <= '0;
      STAY_RESIDENT <= 1'b0;
      CFG_DONE      <= 1'b0;
      CFG_SEL       <= 2'h0;
    end
    else
    begin
      boot_r        <= boot_nxt;
      sw_r          <= sw_nxt;
      cnt_r         <= cnt_nxt;
      BUS_SET       <= bus_nxt;
      SER_SET       <= ser_nxt;
      NV_WR_BUS     <= wr_bus_nxt;
      NV_WR_SER     <= wr_ser_nxt;
      NV_ERASE      <= erase_nxt;
      NV_BUS_D      <= bus_nxt;
      NV_SER_D      <= ser_nxt;
      STAY_RESIDENT <= res_nxt;
      CFG_DONE      <= (boot_r == RLCS_BOOT_DONE);
      CFG_SEL       <= sel;
    end
  end

  // ----------------------------------------------------------------
  // serial port, DCE
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      TXD_O    <= 1'b1;
      DTR_O    <= 1'b0;
      RTS_O    <= 1'b0;
      TX_ALLOW <= 1'b0;
      SER_IN   <= 5'h1f;
    end
    else
    begin
      // [R16] DCE drives TXD, DTR, RTS
      TXD_O    <= TXD_IN;
      DTR_O    <= DTR_IN;
      RTS_O    <= RTS_IN;
      // [R19] hardware handshake only, gated by CTS
      TX_ALLOW <= TX_WANT & ser_sync[1];
      SER_IN   <= ser_sync;
    end
  end
endmodule
`default_nettype wire

//--- bench/rlcs_chk_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module rlcs_chk (
  // clock and reset
  input wire logic                    CLK,
  input wire logic                    RST,
  // remote lines
  input wire logic                    START_N_I,
  input wire logic                    FAULT,
  input wire logic                    UNIT_ON,
  input wire logic                    REQ_START,
  input wire logic                    HALT_OE,
  input wire logic                    ALIVE_OE,
  input wire logic                    START_OE,
  input wire logic                    REMOTE_O,
  input wire rlcs_pkg::rlcs_remote_s  REMOTE_STATE,
  input wire logic                    SAFE_STOP,
  input wire logic                    DO_START,
  input wire logic                    DO_STOP,
  // configuration
  input wire logic [1:0]              CFG_SEL,
  input wire rlcs_pkg::rlcs_bus_set_s BUS_SET,
  input wire logic                    CFG_DONE,
  input wire logic                    NV_WR_BUS,
  input wire logic                    NV_WR_SER,
  input wire logic                    NV_ERASE,
  // serial
  input wire logic                    RTS_IN,
  input wire logic                    RTS_O
);
  import rlcs_pkg::*;
  logic [2:0] run_r;
  logic [2:0] run_nxt;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ----
  // cycles since reset, saturating
  // ----
  always_comb run_nxt = (run_r == 3'h7) ? run_r : run_r + 3'h1;
  always_ff @(posedge CLK) run_r <= RST ? 3'h0 : run_nxt;
  // ----
  // checks
  // ----
  a_halt_drive: assert property (
    !$past(RST) |-> HALT_OE == $past(FAULT))
    else $error("halt drive wrong");
  a_alive_drive: assert property (
    !$past(RST) |-> ALIVE_OE == !$past(UNIT_ON))
    else $error("alive drive wrong");
  a_start_drive: assert property (
    1'b1 |=> START_OE == $past(REQ_START))
    else $error("start drive wrong");
  a_pull_only: assert property (REMOTE_O == 1'b0)
    else $error("line driven high");
  a_halt_stop: assert property (SAFE_STOP |-> DO_STOP)
    else $error("halt without stop");
  a_stop_wins: assert property (DO_STOP |-> !DO_START)
    else $error("start during stop");
  a_sync_depth: assert property (
    run_r >= 3'h4 |-> REMOTE_STATE.start == !$past(START_N_I, 3))
    else $error("start sync latency wrong");
  a_cfg_frozen: assert property (
    CFG_DONE |=> $stable(CFG_SEL) && $stable(BUS_SET))
    else $error("config changed while running");
  a_bus_commit: assert property (
    NV_WR_BUS |-> CFG_SEL == 2'h0 && !CFG_DONE && !NV_WR_SER)
    else $error("bus set write wrong");
  a_ser_commit: assert property (
    NV_WR_SER |-> CFG_SEL == 2'h1 && !CFG_DONE)
    else $error("serial set write wrong");
  a_erase_once: assert property (
    NV_ERASE |-> CFG_SEL == 2'h3 ##1 !NV_ERASE [*4])
    else $error("erase wrong");
  a_rts_copy: assert property (
    !$past(RST) |-> RTS_O == $past(RTS_IN))
    else $error("rts copy wrong");
  c_bus: cover property (NV_WR_BUS);
  c_ser: cover property (NV_WR_SER);
  c_erase: cover property (NV_ERASE);
  c_start: cover property (DO_START);
endmodule
bind rlcs_top rlcs_chk rlcs_chk_inst (
  .CLK          (CLK),
  .RST          (RST),
  .START_N_I    (START_N_I),
  .FAULT        (FAULT),
  .UNIT_ON      (UNIT_ON),
  .REQ_START    (REQ_START),
  .HALT_OE      (HALT_OE),
  .ALIVE_OE     (ALIVE_OE),
  .START_OE     (START_OE),
  .REMOTE_O     (REMOTE_O),
  .REMOTE_STATE (REMOTE_STATE),
  .SAFE_STOP    (SAFE_STOP),
  .DO_START     (DO_START),
  .DO_STOP      (DO_STOP),
  .CFG_SEL      (CFG_SEL),
  .BUS_SET      (BUS_SET),
  .CFG_DONE     (CFG_DONE),
  .NV_WR_BUS    (NV_WR_BUS),
  .NV_WR_SER    (NV_WR_SER),
  .NV_ERASE     (NV_ERASE),
  .RTS_IN       (RTS_IN),
  .RTS_O        (RTS_O)
);
`default_nettype wire

//--- bench/rlcs_peers.sv
`timescale 1ns/1ns
`default_nettype none
module rlcs_peers (
  // line view
  input  wire logic                    clk,
  input  wire logic [6:0]              oe,
  input  wire logic [6:0]              pull,
  output var  logic [6:0]              line,
  // non-volatile store
  input  wire logic                    wr_bus,
  input  wire logic                    wr_ser,
  input  wire logic                    erase,
  input  wire rlcs_pkg::rlcs_bus_set_s bus_d,
  input  wire rlcs_pkg::rlcs_ser_set_s ser_d,
  output var  rlcs_pkg::rlcs_bus_set_s bus_q,
  output var  rlcs_pkg::rlcs_ser_set_s ser_q,
  output var  logic                    valid
);
  import rlcs_pkg::*;
  int n_wr = 0;
  int n_er = 0;
  // ----
  // wired lines, pulled up when released
  // ----
  // any pull wins
  assign line = ~(oe | pull);
  // ----
  // store, one slot per set, kept across resets
  // ----
  // store starts blank: no set is valid until the first commit
  rlcs_bus_set_s bus_m = 6'h3f;
  rlcs_ser_set_s ser_m = 6'h3f;
  assign bus_q = bus_m;
  assign ser_q = ser_m;
  assign valid = (n_wr != 0);
  always @(posedge clk)
  begin
    if (wr_bus)
      bus_m <= bus_d;
    if (wr_ser)
      ser_m <= ser_d;
    n_wr <= n_wr + int'(wr_bus) + int'(wr_ser);
    n_er <= n_er + int'(erase);
  end
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rlcs_pkg::*;
  logic          CLK = 1'b0, RST = 1'b1;
  logic          HALT_N_I, ALIVE_I, READY_I, PREP_N_I, START_N_I;
  logic          STOP_N_I, INJECT_N_I, REMOTE_O, NV_VALID;
  logic          HALT_OE, ALIVE_OE, READY_OE, PREP_OE, START_OE;
  logic          STOP_OE, INJECT_OE, FAULT, UNIT_ON, UNIT_READY;
  logic          REQ_PREP, REQ_START, REQ_STOP, REQ_INJECT;
  logic          SAFE_STOP, PEERS_OFF, DO_PREP, DO_START, DO_STOP;
  logic          NV_WR_BUS, NV_WR_SER, NV_ERASE, STAY_RESIDENT, CFG_DONE;
  logic          RXD_I, DCD_I, DSR_I, CTS_I, RI_I, TXD_IN, DTR_IN, RTS_IN;
  logic          TXD_O, DTR_O, RTS_O, TX_ALLOW, TX_WANT = 1'b1;
  logic [7:0]    CFG_SW = 8'h18;
  logic [1:0]    CFG_SEL;
  logic [4:0]    SER_IN;
  logic [4:0]    ser = 5'h1f;
  logic [2:0]    txc = 3'h5;
  logic [6:0]    pull = 7'h00, loc = 7'h30, line, e;
  logic [5:0]    f;
  rlcs_remote_s  REMOTE_STATE;
  rlcs_bus_set_s NV_BUS_D, NV_BUS_Q, BUS_SET;
  rlcs_ser_set_s NV_SER_D, NV_SER_Q, SER_SET;
  logic [6:0]    pt [6] = '{7'h04, 7'h06, 7'h40, 7'h48, 7'h08, 7'h20};
  logic [4:0]    dt [6] = '{5'h02, 5'h01, 5'h11, 5'h11, 5'h04, 5'h08};
  int            error_cnt = 0, n_checks = 0, n;
  wire logic [6:0] oe = {HALT_OE, ALIVE_OE, READY_OE, PREP_OE, START_OE,
                         STOP_OE, INJECT_OE};
  assign {HALT_N_I, ALIVE_I, READY_I, PREP_N_I, START_N_I, STOP_N_I,
          INJECT_N_I} = line;
  assign {FAULT, UNIT_ON, UNIT_READY, REQ_PREP, REQ_START, REQ_STOP,
          REQ_INJECT} = loc;
  assign {RXD_I, DCD_I, DSR_I, CTS_I, RI_I} = ser;
  assign {TXD_IN, DTR_IN, RTS_IN} = txc;
  always #5 CLK = ~CLK;
  rlcs_top rlcs_top_inst (.*);
  rlcs_peers rlcs_peers_inst (
    .clk    (CLK),
    .oe     (oe),
    .pull   (pull),
    .line   (line),
    .wr_bus (NV_WR_BUS),
    .wr_ser (NV_WR_SER),
    .erase  (NV_ERASE),
    .bus_d  (NV_BUS_D),
    .ser_d  (NV_SER_D),
    .bus_q  (NV_BUS_Q),
    .ser_q  (NV_SER_Q),
    .valid  (NV_VALID)
  );
  // ----
  // helpers
  // ----
  task summarize();
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] x);
    n_checks++;
    if (g !== x)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task tick(input int c);
    repeat (c) @(negedge CLK);
  endtask
  // switch word from {sw1,sw2,sw3..sw8}
  function automatic logic [7:0] mk(input logic [7:0] v);
    for (int j = 0; j < 8; j++)
      mk[j] = v[7-j];
  endfunction
  // power cycle with the given switches, then wait for the capture
  task boot(input logic [7:0] sw);
    int i;
    CFG_SW = sw;
    RST = 1'b1;
    tick(5);
    chk(8'(BUS_SET), 8'h18);
    chk(8'(oe), 8'h30);
    RST = 1'b0;
    i = 0;
    while (CFG_DONE !== 1'b1 && i < 400)
    begin
      tick(1);
      i++;
    end
    if (i == 400)
    begin
      error_cnt++;
      summarize();
    end
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    boot(mk(8'h18));
    chk(8'(CFG_SEL), 8'h00);
    chk(8'(BUS_SET), 8'h18);
    chk(8'(SER_SET), 8'h34);
    CFG_SW = mk(8'h05);
    tick(150);
    chk(8'(BUS_SET), 8'h18);
    chk(8'(rlcs_peers_inst.bus_q), 8'h18);
    boot(CFG_SW);
    chk(8'(BUS_SET), 8'h05);
    chk(8'(rlcs_peers_inst.bus_q), 8'h05);
    for (int i = 0; i < 8; i++)
    begin
      f = {i[2:0], i[0], i[1], i[1] & i[2]};
      boot(mk({2'h1, f}));
      chk(8'(CFG_SEL), 8'h01);
      chk(8'(SER_SET), {2'h0, f});
      chk(8'(rlcs_peers_inst.ser_q), {2'h0, f});
      chk(8'(BUS_SET), 8'h05);
    end
    n = rlcs_peers_inst.n_wr;
    boot(mk(8'hbf));
    chk(8'(rlcs_peers_inst.n_wr), 8'(n));
    boot(mk(8'hc1));
    chk(8'(rlcs_peers_inst.n_er), 8'h01);
    chk(8'(STAY_RESIDENT), 8'h00);
    boot(mk(8'hc8));
    chk(8'(STAY_RESIDENT), 8'h01);
    chk(8'(rlcs_peers_inst.n_er), 8'h01);
    for (int k = 0; k < 14; k++)
    begin
      e = 7'(1 << (k % 7));
      pull = (k < 7) ? e : 7'h00;
      loc = (k < 7) ? 7'h30 : e ^ 7'h30;
      tick(4);
      chk(8'(REMOTE_STATE), 8'(e ^ 7'h30));
      chk(8'(oe), (k < 7) ? 8'h00 : 8'(e));
    end
    loc = 7'h30;
    for (int k = 0; k < 6; k++)
    begin
      pull = pt[k];
      tick(4);
      chk(8'({SAFE_STOP, PEERS_OFF, DO_PREP, DO_START, DO_STOP}),
          8'(dt[k]));
    end
    pull = 7'h00;
    tick(4);
    chk(8'(SER_IN), 8'h1f);
    chk(8'({TXD_O, DTR_O, RTS_O}), 8'h05);
    chk(8'(TX_ALLOW), 8'h01);
    ser = 5'h0d;
    txc = 3'h2;
    tick(4);
    chk(8'(SER_IN), 8'h0d);
    chk(8'({TXD_O, DTR_O, RTS_O}), 8'h02);
    chk(8'(TX_ALLOW), 8'h00);
    ser = 5'h1f;
    TX_WANT = 1'b0;
    tick(4);
    chk(8'(TX_ALLOW), 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
